// ### core/dfc_coef_mem.sv
// two-bank coefficient memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module dfc_coef_mem (
    input wire logic mclk_i, // system clock
    input wire logic srst_i, // sync reset, active high
    input wire logic we_i, // write strobe
    input wire logic wbank_i, // bank written
    input wire logic [6:0] widx_i, // coefficient index
    input wire logic [1:0] wbyte_i, // byte lane 0 = msb
    input wire logic [7:0] wdata_i, // byte written
    input wire logic rbank_i, // bank read
    input wire logic [6:0] ridx_i, // index read
    output logic [23:0] rdata_o // registered read word
);
    logic [23:0] bank_a [dfc_pkg::NUM_COEF];
    logic [23:0] bank_b [dfc_pkg::NUM_COEF];
    // unity n0 slots reset to 0x7FFFFF, all others zero
    function automatic logic [23:0] dfc_reset_val(input int i);
        if ((i < 30 && (i % 5) == 0) || i == dfc_pkg::IDX_IIR_N0) begin
            return dfc_pkg::COEF_UNITY;
        end
        return dfc_pkg::COEF_ZERO;
    endfunction : dfc_reset_val
    // byte writes into one bank, reset restores defaults
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < dfc_pkg::NUM_COEF; i++) begin
            if (srst_i) begin
                bank_a[i] <= dfc_reset_val(i); // [RULE19] [RULE22]
                bank_b[i] <= dfc_reset_val(i);
            end else if (we_i && widx_i == 7'(i)) begin
                if (!wbank_i) begin
                    bank_a[i][(2 - wbyte_i) * 8 +: 8] <= wdata_i; // [RULE16]
                end else begin
                    bank_b[i][(2 - wbyte_i) * 8 +: 8] <= wdata_i;
                end
            end
        end
    end
    // registered read port
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rdata_o <= '0;
        end else if (ridx_i < 7'(dfc_pkg::NUM_COEF)) begin
            rdata_o <= rbank_i ? bank_b[ridx_i] : bank_a[ridx_i];
        end else begin
            rdata_o <= '0;
        end
    end
endmodule : dfc_coef_mem
`default_nettype wire

// ### core/dfc_pkg.sv
// constants shared by the dac filter chain and its coefficient store
// Overview of operation
// RULE1: accepts samples from 8 kHz up to 192 kHz at any rate.
// RULE2: oversampling ratio programmable 1..1024 via page 0 registers 13 and 14.
// RULE3: three interpolation filter types selectable by processing block; the code drives only two, B for block three and A otherwise.
// RULE4: page 0 register 63 bit 7 powers the dac channel.
// RULE5: page 0 register 39 bit 7 is a read-only clipping flag.
// RULE6: block one A+iir+6 biquads, two A+3 biquads, three B+iir+6.
// RULE7: running dac outside adaptive mode locks coefficient access.
// RULE8: page 8 register 1 bit 2 enables adaptive double buffering.
// RULE9: adaptive mode updates coefficients without stopping the dac.
// RULE10: swap request swaps buffers at next sample period start.
// RULE11: swap request bit clears itself after the swap.
// RULE12: page 44 register 1 bit 1 shows buffer in use, toggles each swap.
// RULE13: while running, writes land in the buffer not in use.
// RULE14: while powered down, writes go to the addressed buffer.
// RULE15: seventy coefficients on pages 44-46 (A) and 62-64 (B).
// RULE16: each coefficient is 24-bit two's complement over three bytes.
// RULE17: coefficients are 1.23 fixed point, 0x800000 means minus one.
// RULE18: iir is n0*x + n1*x1 over 2^23 minus d1 feedback.
// RULE19: iir n0 resets 0x7FFFFF at page 46 reg 28; others zero.
// RULE20: biquad n0+2n1 z^-1+n2 z^-2 over 2^23-2d1 z^-1-d2 z^-2.
// RULE21: mono input is left, right or half sum via reg 63 bits 5..4.
// RULE22: first biquad n0 at page 44 reg 12 resets 0x7FFFFF.
// RULE23: locked writes are dropped, locked reads return zero.
// RULE24: arithmetic saturates to 24 bits and raises clipping flag.
package dfc_pkg;
    localparam logic [7:0] PAGE_CTRL = 8'h00;
    localparam logic [7:0] PAGE_ADAPT = 8'h08;
    localparam logic [7:0] PAGE_A0 = 8'h2C;
    localparam logic [7:0] PAGE_A2 = 8'h2E;
    localparam logic [7:0] PAGE_B0 = 8'h3E;
    localparam logic [7:0] PAGE_B2 = 8'h40;
    localparam logic [7:0] REG_PAGE_SEL = 8'h00;
    localparam logic [7:0] REG_OSR_MSB = 8'h0D;
    localparam logic [7:0] REG_OSR_LSB = 8'h0E;
    localparam logic [7:0] REG_BLOCK_SEL = 8'h3C;
    localparam logic [7:0] REG_FLAGS = 8'h27;
    localparam logic [7:0] REG_DAC_SETUP = 8'h3F;
    localparam logic [7:0] REG_BUF_CTRL = 8'h01;
    localparam logic [7:0] REG_COEF_FIRST = 8'h08;
    localparam logic [7:0] REG_BIQ_N0 = 8'h0C;
    localparam logic [7:0] REG_IIR_N0 = 8'h1C; // iir_numerator_zero
    localparam logic [7:0] REG_IIR_N1 = 8'h20; // iir_numerator_one
    localparam logic [7:0] REG_IIR_D1 = 8'h24; // iir_feedback_one
    localparam int BIT_POWER = 7;
    localparam int BIT_CLIP = 7;
    localparam int BIT_ADAPT = 2;
    localparam int BIT_SWAP = 0;
    localparam int BIT_INUSE = 1;
    localparam int SEL_HI = 5;
    localparam int SEL_LO = 4;
    localparam int NUM_COEF = 70;
    localparam int COEF_W = 24;
    localparam int NUM_BIQ = 6;
    localparam int IDX_IIR_N0 = 64;
    localparam int IDX_IIR_N1 = 65;
    localparam int IDX_IIR_D1 = 66;
    localparam int SLOTS_PER_PAGE = 30;
    localparam logic [23:0] COEF_UNITY = 24'h7FFFFF;
    localparam logic [23:0] COEF_ZERO = 24'h000000;
    localparam logic [23:0] SAT_MIN = 24'h800000;
    localparam logic [9:0] OSR_RESET = 10'h080;
    localparam logic [1:0] BLOCK_RESET = 2'h1;
    localparam logic [1:0] SRC_LEFT = 2'h1;
    localparam logic [1:0] SRC_RIGHT = 2'h2;
    localparam logic [1:0] SRC_SUM = 2'h3;
    localparam logic [1:0] BLK_IIR6_A = 2'h1; // block_iir_six_biq_filter_a
    localparam logic [1:0] BLK_3_A = 2'h2; // block_three_biq_filter_a
    localparam logic [1:0] BLK_IIR6_B = 2'h3; // block_iir_six_biq_filter_b
    localparam int MIN_RATE_HZ = 8000;
    localparam int MAX_RATE_HZ = 192000;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_IIR = 4'b0010,
        ST_BIQ = 4'b0100,
        ST_OUT = 4'b1000
    } dfc_state_t;
endpackage : dfc_pkg

// ### core/dfc_top.sv
// dac filter chain with double-buffered coefficients and page registers
`timescale 1ns/10ps
`default_nettype none
module dfc_top (
    input wire logic mclk_i, // system clock 250 MHz
    input wire logic srst_i, // sync reset, active high
    input wire logic reg_wr_i, // register write strobe
    input wire logic reg_rd_i, // register read strobe
    input wire logic [7:0] reg_addr_i, // register in current page
    input wire logic [7:0] reg_wdata_i, // write byte
    input wire logic sample_i, // new sample period start, one pulse
    input wire logic [23:0] left_i, // left sample
    input wire logic [23:0] right_i, // right sample
    output logic [7:0] reg_rdata_o, // read byte, registered
    output logic [23:0] mod_data_o, // sample to modulator
    output logic mod_valid_o, // one pulse per filtered sample
    output logic [9:0] osr_o, // oversampling ratio 0 means 1024
    output logic [1:0] interp_o, // interpolation filter type
    output logic dac_on_o // channel powered
);
    logic [7:0] page;
    logic [9:0] osr;
    logic [1:0] blk_sel;
    logic [1:0] src_sel;
    logic dac_on;
    logic adapt_en;
    logic swap_req;
    logic in_use;
    logic clip;
    // page decode
    wire pg_ctrl = (page == dfc_pkg::PAGE_CTRL);
    wire pg_adapt = (page == dfc_pkg::PAGE_ADAPT);
    wire pg_a = (page >= dfc_pkg::PAGE_A0) && (page <= dfc_pkg::PAGE_A2);
    wire pg_b = (page >= dfc_pkg::PAGE_B0) && (page <= dfc_pkg::PAGE_B2);
    wire is_bufctl = (page == dfc_pkg::PAGE_A0) &&
                     (reg_addr_i == dfc_pkg::REG_BUF_CTRL);
    // coefficient address: 4 registers a slot, 3 bytes used
    wire [7:0] pg_off = pg_a ? 8'(page - dfc_pkg::PAGE_A0)
                             : 8'(page - dfc_pkg::PAGE_B0);
    wire [7:0] rel = 8'(reg_addr_i - dfc_pkg::REG_COEF_FIRST);
    wire slot_ok = (reg_addr_i >= dfc_pkg::REG_COEF_FIRST) &&
                   (rel[1:0] != 2'h3) &&
                   (rel[7:2] < 6'(dfc_pkg::SLOTS_PER_PAGE));
    wire [8:0] cidx_w = 9'(pg_off) * 9'(dfc_pkg::SLOTS_PER_PAGE) +
                        9'(rel[7:2]);
    // slot numbers count from one, memory index sits one below
    wire [6:0] cidx = 7'(cidx_w - 9'h001); // [RULE15]
    wire is_coef = (pg_a || pg_b) && slot_ok && !is_bufctl &&
                   (cidx_w != 9'h000) &&
                   (cidx_w <= 9'(dfc_pkg::NUM_COEF));
    // access lock and bank steering
    wire running = dac_on;
    wire locked = running && !adapt_en; // [RULE7]
    wire coef_we = reg_wr_i && is_coef && !locked; // [RULE23]
    wire wbank = running ? ~in_use : pg_b; // [RULE13] [RULE14]
    wire rd_bank = running ? ~in_use : pg_b;
    // engine side of the memory
    logic eng_rd;
    logic [6:0] eng_idx;
    wire [6:0] mem_ridx = eng_rd ? eng_idx : cidx;
    wire mem_rbank = eng_rd ? in_use : rd_bank;
    logic [23:0] mem_q;
    dfc_coef_mem u_mem (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .we_i(coef_we),
        .wbank_i(wbank),
        .widx_i(cidx),
        .wbyte_i(rel[1:0]),
        .wdata_i(reg_wdata_i),
        .rbank_i(mem_rbank),
        .ridx_i(mem_ridx),
        .rdata_o(mem_q)
    );
    // swap taken at the sample period start
    wire do_swap = swap_req && running && adapt_en && sample_i; // [RULE10] [RULE9]
    wire set_swap = reg_wr_i && is_bufctl && reg_wdata_i[dfc_pkg::BIT_SWAP];
    logic clip_evt;
    wire clr_clip = reg_rd_i && pg_ctrl && (reg_addr_i == dfc_pkg::REG_FLAGS);
    // control register writes
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            page <= '0;
            osr <= dfc_pkg::OSR_RESET;
            blk_sel <= dfc_pkg::BLOCK_RESET;
            src_sel <= dfc_pkg::SRC_LEFT;
            dac_on <= 1'b0;
            adapt_en <= 1'b0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == dfc_pkg::REG_PAGE_SEL) begin
                page <= reg_wdata_i;
            end else if (pg_ctrl && reg_addr_i == dfc_pkg::REG_OSR_MSB) begin
                osr[9:8] <= reg_wdata_i[1:0]; // [RULE2]
            end else if (pg_ctrl && reg_addr_i == dfc_pkg::REG_OSR_LSB) begin
                osr[7:0] <= reg_wdata_i; // [RULE2]
            end else if (pg_ctrl && reg_addr_i == dfc_pkg::REG_BLOCK_SEL) begin
                blk_sel <= reg_wdata_i[1:0];
            end else if (pg_ctrl && reg_addr_i == dfc_pkg::REG_DAC_SETUP) begin
                dac_on <= reg_wdata_i[dfc_pkg::BIT_POWER]; // [RULE4]
                src_sel <= reg_wdata_i[dfc_pkg::SEL_HI:dfc_pkg::SEL_LO];
            end else if (pg_adapt && reg_addr_i == dfc_pkg::REG_BUF_CTRL) begin
                adapt_en <= reg_wdata_i[dfc_pkg::BIT_ADAPT]; // [RULE8]
            end
        end
    end
    // swap request, buffer in use, clip flag; the set wins over the clear
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            swap_req <= 1'b0;
            in_use <= 1'b0;
            clip <= 1'b0;
        end else begin
            swap_req <= set_swap || (swap_req && !do_swap); // [RULE11]
            in_use <= in_use ^ do_swap; // [RULE12]
            clip <= clip_evt || (clip && !clr_clip); // [RULE5] [RULE24]
        end
    end
    // register read mux
    wire [7:0] ctl_rd =
        (reg_addr_i == dfc_pkg::REG_PAGE_SEL) ? page :
        (pg_ctrl && reg_addr_i == dfc_pkg::REG_OSR_MSB) ? {6'h00, osr[9:8]} :
        (pg_ctrl && reg_addr_i == dfc_pkg::REG_OSR_LSB) ? osr[7:0] :
        (pg_ctrl && reg_addr_i == dfc_pkg::REG_BLOCK_SEL) ? {6'h00, blk_sel} :
        (pg_ctrl && reg_addr_i == dfc_pkg::REG_DAC_SETUP) ?
            {dac_on, 1'b0, src_sel, 4'h0} :
        (pg_ctrl && reg_addr_i == dfc_pkg::REG_FLAGS) ? {clip, 7'h00} :
        (pg_adapt && reg_addr_i == dfc_pkg::REG_BUF_CTRL) ?
            {5'h00, adapt_en, 2'h0} :
        is_bufctl ? {6'h00, in_use, swap_req} : 8'h00;
    logic rd_coef_q;
    logic [1:0] rd_byte_q;
    logic [7:0] rd_ctl_q;
    // coefficient reads come from the memory one cycle on
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rd_coef_q <= 1'b0;
            rd_byte_q <= '0;
            rd_ctl_q <= '0;
        end else begin
            rd_coef_q <= reg_rd_i && is_coef && !locked && !eng_rd; // [RULE23]
            rd_byte_q <= rel[1:0];
            rd_ctl_q <= ctl_rd;
        end
    end
    wire [7:0] coef_byte = mem_q[(2 - rd_byte_q) * 8 +: 8];
    // read byte leaves through its own flop
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= rd_coef_q ? coef_byte : rd_ctl_q;
        end
    end
    // datapath: mono mix, then iir and biquads sequenced over the memory
    function automatic logic [23:0] dfc_sat(input logic signed [63:0] v);
        if (v > 64'sh7FFFFF) return dfc_pkg::COEF_UNITY;
        if (v < -64'sh800000) return dfc_pkg::SAT_MIN;
        return v[23:0];
    endfunction : dfc_sat
    wire signed [24:0] sum_lr = $signed({left_i[23], left_i}) +
                                $signed({right_i[23], right_i});
    wire [23:0] mono_in = (src_sel == dfc_pkg::SRC_RIGHT) ? right_i :
                          (src_sel == dfc_pkg::SRC_SUM) ? sum_lr[24:1] :
                          left_i; // [RULE21]
    wire use_iir = (blk_sel != dfc_pkg::BLK_3_A); // [RULE6]
    wire [2:0] nbiq = use_iir ? 3'(dfc_pkg::NUM_BIQ) : 3'h3; // [RULE6]
    dfc_pkg::dfc_state_t state;
    logic [2:0] biq;
    logic [2:0] step;
    logic [23:0] acc_in;
    logic signed [63:0] acc;
    logic [23:0] c0;
    logic [23:0] x1, iy1;
    logic [23:0] bx1 [dfc_pkg::NUM_BIQ];
    logic [23:0] bx2 [dfc_pkg::NUM_BIQ];
    logic [23:0] by1 [dfc_pkg::NUM_BIQ];
    logic [23:0] by2 [dfc_pkg::NUM_BIQ];
    wire signed [23:0] cq = mem_q; // 1.23 coefficient [RULE17]
    // coefficient fetch index per step
    wire [6:0] biq_base = 7'(biq) * 7'h05;
    always_comb begin
        eng_rd = (state != dfc_pkg::ST_IDLE);
        unique case (state)
            dfc_pkg::ST_IIR: eng_idx = 7'(dfc_pkg::IDX_IIR_N0) + 7'(step);
            dfc_pkg::ST_BIQ: eng_idx = biq_base + 7'(step);
            default: eng_idx = '0;
        endcase
    end
    // products of data with fetched coefficient, mac per step
    wire signed [47:0] p_in = $signed(acc_in) * cq;
    wire signed [47:0] p_x1 = $signed(x1) * cq;
    wire signed [47:0] p_iy = $signed(iy1) * cq;
    wire signed [47:0] p_b1 = $signed(bx1[biq]) * cq;
    wire signed [47:0] p_b2 = $signed(bx2[biq]) * cq;
    wire signed [47:0] p_y1 = $signed(by1[biq]) * cq;
    wire signed [47:0] p_y2 = $signed(by2[biq]) * cq;
    wire signed [63:0] iir_y = (acc + 64'(p_iy)) >>> 23; // [RULE18]
    wire signed [63:0] biq_y = (acc + 64'(p_y2)) >>> 23; // [RULE20]
    wire [23:0] iir_s = dfc_sat(iir_y);
    wire [23:0] biq_s = dfc_sat(biq_y);
    // sequencer, one coefficient per cycle after a one-cycle fetch
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state <= dfc_pkg::ST_IDLE;
            step <= '0;
            biq <= '0;
            acc <= '0;
            acc_in <= '0;
            x1 <= '0;
            iy1 <= '0;
            clip_evt <= 1'b0;
            mod_valid_o <= 1'b0;
            mod_data_o <= '0;
            for (int i = 0; i < dfc_pkg::NUM_BIQ; i++) begin
                bx1[i] <= '0;
                bx2[i] <= '0;
                by1[i] <= '0;
                by2[i] <= '0;
            end
        end else begin
            mod_valid_o <= 1'b0;
            clip_evt <= 1'b0;
            unique case (state)
                dfc_pkg::ST_IDLE: begin
                    if (sample_i && dac_on) begin // [RULE1]
                        acc_in <= mono_in;
                        step <= '0;
                        biq <= '0;
                        acc <= '0;
                        state <= use_iir ? dfc_pkg::ST_IIR
                                         : dfc_pkg::ST_BIQ;
                    end
                end
                dfc_pkg::ST_IIR: begin
                    step <= 3'(step + 3'h1);
                    unique case (step)
                        3'h1: acc <= 64'(p_in);
                        3'h2: acc <= acc + 64'(p_x1);
                        3'h3: begin
                            x1 <= acc_in;
                            iy1 <= iir_s;
                            acc_in <= iir_s;
                            clip_evt <= (iir_s != iir_y[23:0]); // [RULE24]
                            acc <= '0;
                            step <= '0;
                            state <= dfc_pkg::ST_BIQ;
                        end
                        default: ;
                    endcase
                end
                dfc_pkg::ST_BIQ: begin
                    step <= 3'(step + 3'h1);
                    unique case (step)
                        3'h1: acc <= 64'(p_in);
                        3'h2: acc <= acc + 64'(p_b1 <<< 1);
                        3'h3: acc <= acc + 64'(p_b2);
                        3'h4: acc <= acc + 64'(p_y1 <<< 1);
                        3'h5: begin
                            bx2[biq] <= bx1[biq];
                            bx1[biq] <= acc_in;
                            by2[biq] <= by1[biq];
                            by1[biq] <= biq_s;
                            acc_in <= biq_s;
                            clip_evt <= (biq_s != biq_y[23:0]); // [RULE24]
                            acc <= '0;
                            step <= '0;
                            biq <= 3'(biq + 3'h1);
                            if (3'(biq + 3'h1) == nbiq) begin
                                state <= dfc_pkg::ST_OUT;
                            end
                        end
                        default: ;
                    endcase
                end
                dfc_pkg::ST_OUT: begin
                    mod_data_o <= acc_in;
                    mod_valid_o <= 1'b1;
                    state <= dfc_pkg::ST_IDLE;
                end
                default: state <= dfc_pkg::ST_IDLE;
            endcase
        end
    end
    // settings presented to the interpolator and modulator
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            osr_o <= dfc_pkg::OSR_RESET;
            interp_o <= dfc_pkg::BLOCK_RESET;
            dac_on_o <= 1'b0;
        end else begin
            osr_o <= osr; // [RULE2]
            interp_o <= (blk_sel == dfc_pkg::BLK_IIR6_B) ? 2'h2 : 2'h1; // [RULE3]
            dac_on_o <= dac_on; // [RULE4]
        end
    end
    property p_swap_clears;
        @(posedge mclk_i) disable iff (srst_i)
        do_swap && !set_swap |=> !swap_req; // [RULE11]
    endproperty
    a_swap_clears: assert property (p_swap_clears) // [RULE11]
        else $error("swap request not cleared");
    property p_inuse_toggles;
        @(posedge mclk_i) disable iff (srst_i)
        do_swap |=> in_use != $past(in_use); // [RULE12]
    endproperty
    a_inuse_toggles: assert property (p_inuse_toggles) // [RULE12]
        else $error("buffer flag did not toggle");
    property p_no_swap_off;
        @(posedge mclk_i) disable iff (srst_i)
        !(running && adapt_en) |=> $stable(in_use);
    endproperty
    a_no_swap_off: assert property (p_no_swap_off) // [RULE10]
        else $error("swap outside adaptive run");
    property p_lock;
        @(posedge mclk_i) disable iff (srst_i)
        locked |-> !coef_we;
    endproperty
    a_lock: assert property (p_lock) // [RULE7]
        else $error("locked coefficient write");
    property p_run_bank;
        @(posedge mclk_i) disable iff (srst_i)
        coef_we && running |-> wbank != in_use;
    endproperty
    a_run_bank: assert property (p_run_bank) // [RULE13]
        else $error("write hit active bank");
    property p_clip_sticky;
        @(posedge mclk_i) disable iff (srst_i)
        clip_evt |=> clip;
    endproperty
    a_clip_sticky: assert property (p_clip_sticky) // [RULE24]
        else $error("clip flag missed");
    property p_out_one;
        @(posedge mclk_i) disable iff (srst_i)
        mod_valid_o |=> !mod_valid_o;
    endproperty
    a_out_one: assert property (p_out_one) // [RULE6]
        else $error("output pulse too long");
    property p_osr;
        @(posedge mclk_i) disable iff (srst_i)
        1'b1 |=> osr_o == $past(osr);
    endproperty
    a_osr: assert property (p_osr) // [RULE2]
        else $error("osr output mismatch");
    c_swap: cover property (@(posedge mclk_i) do_swap);
    c_out: cover property (@(posedge mclk_i) mod_valid_o);
    c_clip: cover property (@(posedge mclk_i) clip_evt);
endmodule : dfc_top
`default_nettype wire

// ### verification/dfc_host_model.sv
// host-side model streaming audio samples into the filter chain
`timescale 1ns/10ps
`default_nettype none
module dfc_host_model (
    input wire logic mclk_i, // system clock
    input wire logic en_i, // stream enable
    output logic sample_o, // sample period start pulse
    output logic [23:0] left_o, // left sample
    output logic [23:0] right_o // right sample
);
    logic [5:0] cnt = 6'h00;
    logic [23:0] acc = 24'h000000;
    // free frame counter; data moves every cycle, valid only at the pulse
    always @(posedge mclk_i) begin
        cnt <= cnt + 6'h01;
        acc <= acc + 24'h13579B;
    end
    // one pulse in 64 cycles stands for any rate, spacing stays above 48
    assign sample_o = en_i && (cnt == 6'h3F);
    assign left_o = acc;
    assign right_o = ~acc;
endmodule : dfc_host_model
`default_nettype wire

// ### verification/dfc_top_test.sv
// self-checking bench for the dac filter chain and coefficient buffers
`timescale 1ns/10ps
`default_nettype none
module dfc_top_test;
    logic mclk_i = 1'b0;
    logic srst_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic en = 1'b0;
    logic sample_i, mod_valid_o, dac_on_o;
    logic [23:0] left_i, right_i, mod_data_o, w, xin;
    logic [7:0] reg_rdata_o, b;
    logic [9:0] osr_o;
    logic [1:0] interp_o;
    logic [31:0] seed = 32'h315E7DAD;
    int err_total = 0;
    int n_tests = 0;
    // clock at 250 MHz
    always #2 mclk_i = ~mclk_i;
    dfc_host_model HOST (.mclk_i(mclk_i), .en_i(en), .sample_o(sample_i),
        .left_o(left_i), .right_o(right_i));
    dfc_top DUT (.mclk_i(mclk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .sample_i(sample_i), .left_i(left_i),
        .right_i(right_i), .reg_rdata_o(reg_rdata_o),
        .mod_data_o(mod_data_o), .mod_valid_o(mod_valid_o), .osr_o(osr_o),
        .interp_o(interp_o), .dac_on_o(dac_on_o));
    // xorshift source and expectation helpers
    function automatic logic [31:0] nxt(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : nxt
    function automatic logic [1:0] exp_interp(input logic [1:0] blk);
        return (blk == 2'h3) ? 2'h2 : 2'h1;
    endfunction : exp_interp
    // default coefficients: iir and six biquads, each near unity gain
    function automatic logic [23:0] exp_flat(input logic [23:0] x);
        for (int s = 0; s < 7; s++) begin
            if (x == 24'h800000) x = 24'h800001;
            else if (!x[23] && x != 24'h0) x = x - 24'h1;
        end
        return x;
    endfunction : exp_flat
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic tick;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask : tick
    // one register byte write, strobe held for a single edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        #1;
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge mclk_i);
        #1;
        reg_wr_i = 1'b0;
    endtask : wr
    // read byte is taken just after the edge that follows the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        #1;
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(posedge mclk_i);
        #1;
        reg_rd_i = 1'b0;
        @(posedge mclk_i);
        #1;
        d = reg_rdata_o;
    endtask : rd
    // whole coefficient, msb byte first
    task automatic wc(input logic [7:0] p, r, input logic [23:0] v);
        wr(8'h00, p);
        wr(r, v[23:16]);
        wr(r + 8'h01, v[15:8]);
        wr(r + 8'h02, v[7:0]);
    endtask : wc
    task automatic rc(input logic [7:0] p, r, output logic [23:0] v);
        wr(8'h00, p);
        rd(r, v[23:16]);
        rd(r + 8'h01, v[15:8]);
        rd(r + 8'h02, v[7:0]);
    endtask : rc
    // wait for a sample period, then for the filtered result
    task automatic run_one;
        int i;
        i = 0;
        while (sample_i !== 1'b1 && i < 200) begin
            @(posedge mclk_i);
            #1;
            i++;
        end
        xin = left_i;
        i = 0;
        while (mod_valid_o !== 1'b1 && i < 100) begin
            @(posedge mclk_i);
            #1;
            i++;
        end
        chk({23'h0, mod_valid_o}, 24'h1);
    endtask : run_one
    task automatic results;
        if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    // main sequence
    initial begin
        repeat (16) @(posedge mclk_i);
        #1;
        srst_i = 1'b0;
        chk({14'h0, osr_o}, 24'h80);
        chk({22'h0, interp_o}, 24'h1);
        chk({23'h0, dac_on_o}, 24'h0);
        rd(8'h27, b);
        chk({16'h0, b}, 24'h0);
        rc(8'h2E, 8'h1C, w);
        chk(w, 24'h7FFFFF);
        rc(8'h2E, 8'h20, w);
        chk(w, 24'h000000);
        rc(8'h2C, 8'h0C, w);
        chk(w, 24'h7FFFFF);
        seed = nxt(seed);
        wr(8'h00, 8'h00);
        wr(8'h0D, 8'h02);
        wr(8'h0E, seed[7:0]);
        tick;
        chk({14'h0, osr_o}, {16'h2, seed[7:0]});
        for (int k = 1; k < 4; k++) begin
            wr(8'h3C, k[7:0]);
            tick;
            chk({22'h0, interp_o}, {22'h0, exp_interp(k[1:0])});
        end
        seed = nxt(seed);
        wc(8'h3E, 8'h0C, seed[23:0]);
        rc(8'h3E, 8'h0C, w);
        chk(w, seed[23:0]);
        rc(8'h2C, 8'h0C, w);
        chk(w, 24'h7FFFFF);
        wr(8'h00, 8'h00);
        wr(8'h3F, 8'h90);
        tick;
        chk({23'h0, dac_on_o}, 24'h1);
        en = 1'b1;
        run_one;
        en = 1'b0;
        chk(mod_data_o, exp_flat(xin));
        wc(8'h2C, 8'h0C, 24'h123456);
        rc(8'h2C, 8'h0C, w);
        chk(w, 24'h000000);
        wr(8'h00, 8'h00);
        wr(8'h3F, 8'h00);
        rc(8'h2C, 8'h0C, w);
        chk(w, 24'h7FFFFF);
        wr(8'h00, 8'h08);
        wr(8'h01, 8'h04);
        wr(8'h00, 8'h00);
        wr(8'h3F, 8'h90);
        seed = nxt(seed);
        wc(8'h2C, 8'h10, seed[23:0]);
        wr(8'h01, 8'h01);
        rd(8'h01, b);
        chk({22'h0, b[1:0]}, 24'h1);
        en = 1'b1;
        run_one;
        en = 1'b0;
        rd(8'h01, b);
        chk({22'h0, b[1:0]}, 24'h2);
        wr(8'h00, 8'h00);
        wr(8'h3F, 8'h00);
        rc(8'h3E, 8'h10, w);
        chk(w, seed[23:0]);
        rc(8'h2C, 8'h10, w);
        chk(w, 24'h000000);
        results;
    end
    // hang guard well past the expected run length
    initial begin
        #200000;
        err_total++;
        results;
    end
endmodule : dfc_top_test
`default_nettype wire
